// >>> design/t8cc_pkg.sv
// Constants for the 8-bit capture timer and its register bank.
package t8cc_pkg;
    // ------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CONTROL = 8'h00; // Timer control.
    localparam logic [7:0] IDX_HOLD_HIGH = 8'h07; // Word reload high byte.
    localparam logic [7:0] IDX_WORD_CAP_LOW = 8'h08; // Word capture low byte.
    localparam logic [7:0] IDX_WORD_CAP_HIGH = 8'h09; // Word capture high byte.
    localparam logic [7:0] IDX_CAP_LOW_LEVEL = 8'h0A; // Count while input is 0.
    localparam logic [7:0] IDX_CAP_HIGH_LEVEL = 8'h0B; // Count while input is 1.
    localparam logic [7:0] IDX_LOAD = 8'h0C; // Byte timer initial value.
    localparam logic [7:0] IDX_INT_STATUS = 8'h0D; // Sticky event flags.
    localparam logic [7:0] IDX_INT_MASK = 8'h0E; // Event mask.
    localparam int ADDR_SHIFT = 2; // Word index to byte address shift.

    // ------------------------------------------------------------
    // Control register field positions.
    // ------------------------------------------------------------
    localparam int CTL_ENABLE = 7; // Timer enable, reads back running.
    localparam int CTL_SINGLE = 6; // 1 single pass, 0 modulo-N.
    localparam int CTL_TIMEOUT = 5; // Timeout flag, write one to clear.
    localparam int CTL_INT_MASK = 1; // Timeout interrupt enable.
    localparam int CTL_PIN_SEL = 0; // Shared pin source select.

    // ------------------------------------------------------------
    // Event flag positions in the status and mask registers.
    // ------------------------------------------------------------
    localparam int EVT_TIMEOUT = 0; // Terminal count reached.
    localparam int EVT_CAP_HIGH = 1; // High level capture stored.
    localparam int EVT_CAP_LOW = 2; // Low level capture stored.
    localparam int EVT_COUNT = 3; // Number of event flags.

    // ------------------------------------------------------------
    // Reset values and timing.
    // ------------------------------------------------------------
    localparam logic [7:0] BYTE_ZERO = 8'h00; // Cleared byte.
    localparam logic [7:0] BYTE_FULL = 8'hFF; // Saturated byte.
    localparam logic [7:0] LOAD_RESET = 8'hFF; // Initial load value.
    localparam logic [15:0] WORD_ZERO = 16'h0000; // Cleared word.
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000; // Idle read data.
    localparam int TIMER_CLK_NS = 40; // Timer clock period in ns.
    localparam int CORE_CLK_NS = 10; // Core clock period in ns.
    localparam int TICK_DIV = TIMER_CLK_NS / CORE_CLK_NS; // Core cycles per tick.
    localparam logic [1:0] PRESCALE_LAST = 2'(TICK_DIV - 1); // Last divider count.
endpackage

// >>> design/t8cc_sticky_flags.sv
// Sticky event flags with write-one-to-clear, set winning over clear.
`timescale 1ns/1ps
module t8cc_sticky_flags #(
    parameter int WIDTH = 3
) (
    // Clock, reset and freeze.
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Stop-mode recovery clears every flag.
    input wire logic recover,
    // Set and clear requests, one bit per flag.
    input wire logic [WIDTH-1:0] setBits,
    input wire logic [WIDTH-1:0] clearBits,
    // Current flag values.
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] next_flags; // Next flag values.

    // A flag set in the same cycle as its clear stays set.
    always_comb begin
        next_flags = (flags & ~clearBits) | setBits;
        if (recover) begin
            next_flags = '0;
        end
    end

    // The flags hold their value while the clock enable is low.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags <= '0;
        end else if (ce) begin
            flags <= next_flags;
        end
    end
endmodule // t8cc_sticky_flags

// >>> design/t8cc_timer.sv
// Byte timer with level capture, word capture and an APB register slave.
// Function
// - High capture holds count while input one.
// - Low capture holds count while input zero.
// - Word capture high byte is the MSB.
// - Word capture low byte is the LSB.
// - Capture registers are read only bytes.
// - Read/write hold byte holds word MSB.
// - Control bit one gates timeout interrupt.
// - Control bit zero selects shared pin source.
// - Writing one to enable starts counting.
// - Modulo-N mode reloads at terminal count.
// - Single-pass mode stops at terminal count.
// - Terminal count sets the timeout flag.
// - Timeout clears only by writing one; stop-mode recovery here clears it too.
// - First timer tick may come early.
// - Double-star bits survive stop-mode recovery.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module t8cc_timer (
    // Clock, reset and freeze.
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Stop-mode recovery pulse.
    input wire logic stopRecovery,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Monitored input and ordinary port data.
    input wire logic monitorInput,
    input wire logic portOutData,
    // Shared output pin and interrupt.
    output logic sharedOutputPin,
    output logic irq
);
    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    typedef struct packed {
        logic enable; // Byte timer running.
        logic single; // Single-pass mode.
        logic intMask; // Timeout interrupt enable.
        logic pinSel; // Shared pin carries the timer output.
        logic [1:0] maskOther; // Mask bits of the capture events.
        logic [7:0] loadValue; // Byte timer initial value.
        logic [7:0] count; // Byte timer down counter.
        logic timerOut; // Byte timer output level.
        logic [7:0] holdHigh; // Word timer reload high byte.
        logic [15:0] wordCount; // Word timer up counter.
        logic [7:0] wordCapMsb; // Captured word high byte.
        logic [7:0] wordCapLsb; // Captured word low byte.
        logic [7:0] highLevel; // Ticks counted while input was one.
        logic [7:0] lowLevel; // Ticks counted while input was zero.
        logic [7:0] runLength; // Ticks of the current input level.
        logic inputLast; // Input level of the last cycle.
        logic [1:0] prescale; // Timer clock divider.
        logic [31:0] prdata; // Registered read data.
        logic pready; // Registered ready.
        logic pslverr; // Registered error.
        logic pinOut; // Registered shared pin.
        logic irq; // Registered interrupt.
    } t8cc_state_type;

    t8cc_state_type state; // Present state.
    t8cc_state_type next_state; // Next state.

    // ------------------------------------------------------------
    // Event flags.
    // ------------------------------------------------------------
    logic [t8cc_pkg::EVT_COUNT-1:0] evtSet; // Events of this cycle.
    logic [t8cc_pkg::EVT_COUNT-1:0] evtClear; // Write-one-to-clear bits.
    logic [t8cc_pkg::EVT_COUNT-1:0] evtFlags; // Sticky event flags.
    logic [t8cc_pkg::EVT_COUNT-1:0] evtMask; // Mask in event layout.

    t8cc_sticky_flags #(
        .WIDTH(t8cc_pkg::EVT_COUNT)
    ) flagsInst (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .recover(stopRecovery),
        .setBits(evtSet),
        .clearBits(evtClear),
        .flags(evtFlags)
    );

    // ------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------
    logic setupPhase; // First cycle of a transfer.
    logic writeDone; // Write completes at this edge.
    logic [7:0] regIndex; // Word index of the address.
    logic aligned; // Address is word aligned.
    logic tick; // One timer clock period has elapsed.
    logic inputEdge; // Monitored input changed.

    // Bus phase, register index, tick and input edge.
    always_comb begin
        // No new setup while an answer stands.
        setupPhase = psel && !penable && !state.pready;
        // A write lands with the answer, never on an error.
        writeDone = psel && penable && state.pready && pwrite && !state.pslverr;

        // One aligned word per register.
        regIndex = paddr >> t8cc_pkg::ADDR_SHIFT;
        aligned = (paddr[1:0] == 2'h0);

        // The divider runs freely, so the first tick after an enable may
        // come at any point and be shorter than a full period.
        tick = (state.prescale == t8cc_pkg::PRESCALE_LAST);
        inputEdge = monitorInput != state.inputLast;
        evtMask = {state.maskOther, state.intMask};
    end

    // ------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------
    // Timers, captures, bus answer and register writes.
    always_comb begin
        // Hold everything unless a branch changes it.
        next_state = state;
        evtSet = '0;
        evtClear = '0;

        // The timer clock divider free runs.
        if (tick) begin
            // Wrap after the last count.
            next_state.prescale = 2'h0;
        end else begin
            next_state.prescale = state.prescale + 2'h1;
        end

        // Byte timer counts down one per tick while enabled.
        if (state.enable && tick) begin
            if (state.count == t8cc_pkg::BYTE_ZERO) begin
                evtSet[t8cc_pkg::EVT_TIMEOUT] = 1'b1;
                next_state.timerOut = !state.timerOut;
                if (state.single) begin
                    // Single pass ends here.
                    next_state.enable = 1'b0;
                end else begin
                    // Modulo-N starts the next period.
                    next_state.count = state.loadValue;
                end
            end else begin
                // Count down one tick.
                next_state.count = state.count - 8'h01;
            end
        end

        // Run length of the present input level, saturating.
        // A level longer than a byte reads as full.
        if (state.enable && tick && state.runLength != t8cc_pkg::BYTE_FULL) begin
            next_state.runLength = state.runLength + 8'h01;
        end

        // Word timer counts ticks while the byte timer runs.
        if (state.enable && tick) begin
            next_state.wordCount = state.wordCount + 16'h0001;
        end

        // On an input change the finished level's length is stored.
        next_state.inputLast = monitorInput;

        // Only an enabled timer measures levels.
        if (inputEdge && state.enable) begin
            if (state.inputLast) begin
                // The old level was one.
                next_state.highLevel = state.runLength;
                evtSet[t8cc_pkg::EVT_CAP_HIGH] = 1'b1;
            end else begin
                // The old level was zero.
                next_state.lowLevel = state.runLength;
                evtSet[t8cc_pkg::EVT_CAP_LOW] = 1'b1;
            end
            next_state.runLength = t8cc_pkg::BYTE_ZERO;
            // A rising edge captures the word and restarts it from the hold byte.
            if (monitorInput) begin
                next_state.wordCapMsb = state.wordCount[15:8];
                next_state.wordCapLsb = state.wordCount[7:0];
                next_state.wordCount = {state.holdHigh, t8cc_pkg::BYTE_ZERO};
            end
        end

        // Bus answer: data and ready are prepared in the setup cycle.
        next_state.pready = setupPhase;
        // Outside a setup cycle the answer returns to idle.
        next_state.pslverr = 1'b0;
        next_state.prdata = t8cc_pkg::DATA_ZERO;
        if (setupPhase) begin
            // Refuse an address that is not word aligned.
            next_state.pslverr = !aligned;
            case (regIndex)
                // Control fields read back in place.
                t8cc_pkg::IDX_CONTROL: begin
                    next_state.prdata[t8cc_pkg::CTL_ENABLE] = state.enable;
                    next_state.prdata[t8cc_pkg::CTL_SINGLE] = state.single;
                    next_state.prdata[t8cc_pkg::CTL_TIMEOUT] =
                        evtFlags[t8cc_pkg::EVT_TIMEOUT];
                    next_state.prdata[t8cc_pkg::CTL_INT_MASK] = state.intMask;
                    next_state.prdata[t8cc_pkg::CTL_PIN_SEL] = state.pinSel;
                end

                t8cc_pkg::IDX_HOLD_HIGH: begin
                    next_state.prdata[7:0] = state.holdHigh;
                end

                // Captures read back; writes never reach them.
                t8cc_pkg::IDX_WORD_CAP_LOW: begin
                    next_state.prdata[7:0] = state.wordCapLsb;
                end

                t8cc_pkg::IDX_WORD_CAP_HIGH: begin
                    next_state.prdata[7:0] = state.wordCapMsb;
                end

                t8cc_pkg::IDX_CAP_LOW_LEVEL: begin
                    next_state.prdata[7:0] = state.lowLevel;
                end

                t8cc_pkg::IDX_CAP_HIGH_LEVEL: begin
                    next_state.prdata[7:0] = state.highLevel;
                end

                t8cc_pkg::IDX_LOAD: begin
                    next_state.prdata[7:0] = state.loadValue;
                end

                // Status and mask in event layout.
                t8cc_pkg::IDX_INT_STATUS: begin
                    next_state.prdata[t8cc_pkg::EVT_COUNT-1:0] = evtFlags;
                end

                t8cc_pkg::IDX_INT_MASK: begin
                    next_state.prdata[t8cc_pkg::EVT_COUNT-1:0] = evtMask;
                end

                default: begin
                    // Unmapped addresses answer with an error.
                    next_state.pslverr = 1'b1;
                end
            endcase
        end

        // Register writes take effect at the completing edge.
        // Errored transfers never get here.
        if (writeDone) begin
            case (regIndex)
                t8cc_pkg::IDX_CONTROL: begin
                    // Writing one starts the timer from the initial value.
                    // A rewrite of a running timer keeps its count.
                    if (pwdata[t8cc_pkg::CTL_ENABLE] && !state.enable) begin
                        next_state.count = state.loadValue;
                        // A fresh run starts with the enable.
                        next_state.runLength = t8cc_pkg::BYTE_ZERO;
                    end
                    // Mode, interrupt gate and pin source follow the byte.
                    next_state.enable = pwdata[t8cc_pkg::CTL_ENABLE];
                    next_state.single = pwdata[t8cc_pkg::CTL_SINGLE];
                    next_state.intMask = pwdata[t8cc_pkg::CTL_INT_MASK];
                    next_state.pinSel = pwdata[t8cc_pkg::CTL_PIN_SEL];
                    // Only a written one clears the timeout flag.
                    evtClear[t8cc_pkg::EVT_TIMEOUT] = pwdata[t8cc_pkg::CTL_TIMEOUT];
                end

                // Reload high byte of the word timer.
                t8cc_pkg::IDX_HOLD_HIGH: begin
                    next_state.holdHigh = pwdata[7:0];
                end

                // Initial value of the byte timer.
                t8cc_pkg::IDX_LOAD: begin
                    next_state.loadValue = pwdata[7:0];
                end

                // Written ones clear the matching flags.
                t8cc_pkg::IDX_INT_STATUS: begin
                    evtClear = pwdata[t8cc_pkg::EVT_COUNT-1:0];
                end

                // Mask bit zero is the control's interrupt gate.
                t8cc_pkg::IDX_INT_MASK: begin
                    next_state.intMask = pwdata[t8cc_pkg::EVT_TIMEOUT];
                    next_state.maskOther = pwdata[t8cc_pkg::EVT_COUNT-1:1];
                end

                default: begin
                    // Capture registers ignore writes.
                end
            endcase
        end

        // Stop-mode recovery resets all but the double-star bit.
        // Captures, load, hold, capture mask bits and the word count survive as well.
        if (stopRecovery) begin
            next_state.enable = 1'b0;
            next_state.single = 1'b0;
            next_state.pinSel = 1'b0;
            next_state.count = t8cc_pkg::BYTE_ZERO;
            next_state.timerOut = 1'b0;
            next_state.runLength = t8cc_pkg::BYTE_ZERO;
        end

        // Shared pin carries the timer output or the port data.
        next_state.pinOut = next_state.pinSel ? next_state.timerOut : portOutData;
        // Interrupt is high while an unmasked flag is set.
        next_state.irq = |(evtFlags & evtMask);
    end

    // ------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------
    // All state freezes while the clock enable is low.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // Only the initial value resets to a non-zero byte.
            state <= '0;
            state.loadValue <= t8cc_pkg::LOAD_RESET;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from the state register.
    // ------------------------------------------------------------
    always_comb begin
        // Bus answer.
        prdata = state.prdata;
        pready = state.pready;
        pslverr = state.pslverr;
        // Pin and interrupt.
        sharedOutputPin = state.pinOut;
        irq = state.irq;
    end
endmodule // t8cc_timer

// >>> verification/t8cc_timer_props.sv
// Port checker for the capture timer: bus handshake, shared pin and interrupt gating.
`timescale 1ns/1ps
module t8cc_timer_props (
    // Clock, reset and freeze.
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic stopRecovery,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and interrupt.
    input wire logic monitorInput,
    input wire logic portOutData,
    input wire logic sharedOutputPin,
    input wire logic irq
);
    // Byte addresses of the control and mask registers.
    localparam logic [7:0] ADDR_CTL = 8'(t8cc_pkg::IDX_CONTROL << t8cc_pkg::ADDR_SHIFT);
    localparam logic [7:0] ADDR_MASK = 8'(t8cc_pkg::IDX_INT_MASK << t8cc_pkg::ADDR_SHIFT);
    logic selPin; // Pin select as software last left it.
    logic [2:0] maskAll; // Event mask as software last left it.
    logic wrDone; // A write completes at this edge.
    assign wrDone = psel && penable && pready && pwrite && ce;
    // Shadow copies follow completed writes; recovery drops the pin select only.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            selPin <= 1'b0;
            maskAll <= 3'h0;
        end else begin
            if (ce && stopRecovery) begin
                selPin <= 1'b0;
            end else if (wrDone && paddr == ADDR_CTL) begin
                selPin <= pwdata[t8cc_pkg::CTL_PIN_SEL];
            end
            if (wrDone && paddr == ADDR_CTL) begin
                maskAll[0] <= pwdata[t8cc_pkg::CTL_INT_MASK];
            end else if (wrDone && paddr == ADDR_MASK) begin
                maskAll <= pwdata[2:0];
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // A setup cycle and a one-cycle answer.
    sequence s_setup;
        psel && !penable && !pready && ce;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_ready_after_setup;
        s_setup |=> pready;
    endproperty
    property p_ready_pulse;
        pready && ce |-> s_answer;
    endproperty
    property p_unaligned_err;
        s_setup ##0 (paddr[1:0] != 2'h0) |=> pslverr;
    endproperty
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    property p_rdata_idle;
        !pready |-> prdata == t8cc_pkg::DATA_ZERO;
    endproperty
    property p_rdata_upper;
        pready |-> prdata[31:8] == 24'h00_0000;
    endproperty
    property p_pin_port;
        !$past(rst) && $past(ce) && !selPin |-> sharedOutputPin == $past(portOutData);
    endproperty
    property p_irq_masked;
        !$past(rst) && $past(ce) && $past(maskAll) == 3'h0 |-> !irq;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no answer after setup");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    a_unaligned_err: assert property (p_unaligned_err) else $error("unaligned access not refused");
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper read data not zero");
    a_pin_port: assert property (p_pin_port) else $error("pin not following port data");
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt while masked");
endmodule // t8cc_timer_props

bind t8cc_timer t8cc_timer_props t8cc_timer_props_i (.core_clk, .rst, .ce, .stopRecovery, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .monitorInput, .portOutData,
    .sharedOutputPin, .irq);

// >>> verification/t8cc_timer_tb.sv
// Self-checking bench for the capture timer's registers, pins and interrupt.
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin errCount++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module t8cc_timer_tb;
    logic core_clk, rst, ce, stopRecovery, psel, penable, pwrite; // Bench-driven controls.
    logic [7:0] paddr; // Byte address.
    logic [31:0] pwdata, prdata; // Bus data.
    logic pready, pslverr, monitorInput, portOutData, sharedOutputPin, irq; // Pins.
    logic [31:0] rdat; // Data of the last transfer.
    logic rerr; // Error of the last transfer.
    int errCount = 0; // Mismatches.
    int checked = 0; // Comparisons.
    t8cc_timer t8cc_timer_i (.core_clk, .rst, .ce, .stopRecovery, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .monitorInput, .portOutData,
        .sharedOutputPin, .irq);
    // Free-running 100 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Byte address of a register index.
    function automatic logic [7:0] ba(input logic [7:0] idx);
        return 8'(idx << t8cc_pkg::ADDR_SHIFT);
    endfunction
    // One APB transfer; waits for ready, only the watchdog ends a hang.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, ba(idx), {24'h00_0000, d});
    endtask
    // Read a register and compare it with an exact value.
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, ba(idx), t8cc_pkg::DATA_ZERO);
        `CHK({rerr, rdat}, {1'b0, 24'h00_0000, exp})
    endtask
    // Read a count that may be one tick off either way.
    task automatic rdrange(input logic [7:0] idx, input logic [7:0] lo, input logic [7:0] hi);
        xfer(1'b0, ba(idx), t8cc_pkg::DATA_ZERO);
        `CHK(rdat[7:0] >= lo && rdat[7:0] <= hi && rdat[31:8] == 24'h00_0000, 1'b1)
    endtask
    // Print the verdict and end the run.
    task automatic summarize();
        if (errCount == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog against a hang; the tests need about 400 cycles.
    initial begin
        repeat (5000) @(posedge core_clk);
        errCount++;
        summarize();
    end
    // Main sequence.
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        {stopRecovery, psel, penable, pwrite, monitorInput, portOutData} = 6'h00;
        paddr = 8'h00;
        pwdata = t8cc_pkg::DATA_ZERO;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rdchk(t8cc_pkg::IDX_CONTROL, 8'h00);
        rdchk(t8cc_pkg::IDX_LOAD, t8cc_pkg::LOAD_RESET);
        rdchk(t8cc_pkg::IDX_INT_MASK, 8'h00);
        xfer(1'b0, ba(8'h0F), t8cc_pkg::DATA_ZERO);
        `CHK(rerr, 1'b1)
        xfer(1'b0, 8'h01, t8cc_pkg::DATA_ZERO);
        `CHK(rerr, 1'b1)
        // Capture registers ignore writes; the hold byte keeps them.
        wr(t8cc_pkg::IDX_CAP_HIGH_LEVEL, 8'hAA);
        rdchk(t8cc_pkg::IDX_CAP_HIGH_LEVEL, 8'h00);
        wr(t8cc_pkg::IDX_WORD_CAP_LOW, 8'h55);
        rdchk(t8cc_pkg::IDX_WORD_CAP_LOW, 8'h00);
        wr(t8cc_pkg::IDX_HOLD_HIGH, 8'h5A);
        rdchk(t8cc_pkg::IDX_HOLD_HIGH, 8'h5A);
        // Shared pin: port data first, then the idle timer output.
        portOutData <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK(sharedOutputPin, 1'b1)
        wr(t8cc_pkg::IDX_CONTROL, 8'h01);
        repeat (3) @(posedge core_clk);
        `CHK(sharedOutputPin, 1'b0)
        // Modulo-N run, masked timeout, then stop and clear in two writes.
        wr(t8cc_pkg::IDX_LOAD, 8'h02);
        wr(t8cc_pkg::IDX_CONTROL, 8'h80);
        repeat (40) @(posedge core_clk);
        rdchk(t8cc_pkg::IDX_CONTROL, 8'hA0);
        `CHK(irq, 1'b0)
        rdchk(t8cc_pkg::IDX_INT_STATUS, 8'h01);
        wr(t8cc_pkg::IDX_CONTROL, 8'h02);
        repeat (8) @(posedge core_clk);
        rdchk(t8cc_pkg::IDX_CONTROL, 8'h22);
        `CHK(irq, 1'b1)
        wr(t8cc_pkg::IDX_CONTROL, 8'h22);
        rdchk(t8cc_pkg::IDX_CONTROL, 8'h02);
        `CHK(irq, 1'b0)
        // Single pass stops itself at terminal count.
        wr(t8cc_pkg::IDX_LOAD, 8'h01);
        wr(t8cc_pkg::IDX_CONTROL, 8'hC0);
        repeat (40) @(posedge core_clk);
        rdchk(t8cc_pkg::IDX_CONTROL, 8'h60);
        wr(t8cc_pkg::IDX_CONTROL, 8'h20);
        rdchk(t8cc_pkg::IDX_CONTROL, 8'h00);
        // Level captures: 10 ticks high, 20 ticks low, rises 30 ticks apart.
        wr(t8cc_pkg::IDX_LOAD, 8'hFF);
        wr(t8cc_pkg::IDX_INT_STATUS, 8'h07);
        wr(t8cc_pkg::IDX_CONTROL, 8'h80);
        repeat (8) @(posedge core_clk);
        monitorInput <= 1'b1;
        repeat (40) @(posedge core_clk);
        monitorInput <= 1'b0;
        repeat (80) @(posedge core_clk);
        monitorInput <= 1'b1;
        repeat (8) @(posedge core_clk);
        wr(t8cc_pkg::IDX_CONTROL, 8'h00);
        rdrange(t8cc_pkg::IDX_CAP_HIGH_LEVEL, 8'h09, 8'h0B);
        rdrange(t8cc_pkg::IDX_CAP_LOW_LEVEL, 8'h13, 8'h15);
        rdchk(t8cc_pkg::IDX_WORD_CAP_HIGH, 8'h5A);
        rdrange(t8cc_pkg::IDX_WORD_CAP_LOW, 8'h1D, 8'h1F);
        rdchk(t8cc_pkg::IDX_INT_STATUS, 8'h06);
        // Unmasked capture flags raise the interrupt.
        wr(t8cc_pkg::IDX_INT_MASK, 8'h06);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b1)
        wr(t8cc_pkg::IDX_INT_MASK, 8'h00);
        // Stop-mode recovery keeps the mask but drops the pin select.
        wr(t8cc_pkg::IDX_CONTROL, 8'h03);
        // A frozen block ignores a recovery pulse.
        ce <= 1'b0;
        stopRecovery <= 1'b1;
        repeat (2) @(posedge core_clk);
        {ce, stopRecovery} <= 2'b10;
        rdchk(t8cc_pkg::IDX_CONTROL, 8'h03);
        @(posedge core_clk);
        stopRecovery <= 1'b1;
        @(posedge core_clk);
        stopRecovery <= 1'b0;
        rdchk(t8cc_pkg::IDX_CONTROL, 8'h02);
        rdchk(t8cc_pkg::IDX_INT_MASK, 8'h01);
        repeat (3) @(posedge core_clk);
        `CHK(sharedOutputPin, 1'b1)
        summarize();
    end
endmodule // t8cc_timer_tb
